// ### hdl/edb_bus_ctrl.sv
// Data-memory steering, strobe stretch, port-4 chip selects and code bank line.
`timescale 1ns/10ps
`default_nettype none
module edb_bus_ctrl
	import edb_pkg::*;
(
	input  wire logic        clk,          // System clock.
	input  wire logic        rst_n,        // Synchronous reset, active low.
	input  wire logic        sfr_wr,       // Register write strobe.
	input  wire logic        sfr_rd,       // Register read strobe.
	input  wire logic        sfr_rmw,      // Read is part of read-modify-write.
	input  wire logic [7:0]  sfr_addr,     // Register address.
	input  wire logic [7:0]  sfr_wdata,    // Register write data.
	output logic      [7:0]  sfr_rdata,    // Register read data, next cycle.
	input  wire logic        mx_req,       // Start of an external move, one cycle.
	input  wire logic        mx_write,     // Move direction, high for write.
	input  wire logic [15:0] mx_addr,      // Move address.
	input  wire logic [7:0]  mx_wdata,     // Move write data.
	output logic             mx_done,      // Move finished, one-cycle pulse.
	output logic      [7:0]  mx_rdata,     // Move read data, valid with done.
	input  wire logic        code_loader,  // Fetch from the loader bank.
	input  wire logic        code_fetch,   // A code fetch or table read is active.
	output logic             code_bank,    // Selected application bank, high for bank 1.
	output logic             loader_sel,   // Loader bank selected.
	input  wire logic [7:0]  p0_in,        // Port 0 pin levels.
	output logic      [7:0]  p0_out,       // Port 0 output value.
	output logic      [7:0]  p0_oe,        // Port 0 drive enables.
	output logic             p0_pullup,    // Port 0 pull-ups on.
	output logic      [7:0]  p2_out,       // Port 2 high address byte.
	output logic             p2_addr_en,   // Port 2 carries address.
	input  wire logic [7:0]  p1_in,        // Port 1 pin levels.
	output logic      [7:0]  p1_out,       // Port 1 output, the port 1 latch value.
	input  wire logic [3:0]  p4_in,        // Port 4 pin levels.
	output logic      [3:0]  p4_out,       // Port 4 output, chip selects low active.
	output logic             rd_n,         // External read strobe, active low.
	output logic             wr_n,         // External write strobe, active low.
	output logic             ale           // Address latch enable.
);
	typedef struct packed {
		edb_state_t  st;
		logic [7:0]  stretch;
		logic [7:0]  ctrl_a;
		logic [7:0]  ctrl_b;
		logic [63:0] bases;
		logic [7:0]  misc;
		logic [7:0]  bank;
		logic [7:0]  xctl;
		logic [7:0]  p0_lat;
		logic [7:0]  p1_lat;
		logic [3:0]  p4_lat;
		logic        key_half;
		logic [4:0]  key_cnt;
		logic [1:0]  mc_div;
		logic [3:0]  mc_left;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdat;
		logic [7:0]  rdata;
		logic [7:0]  mrdata;
		logic        done;
		logic [7:0]  p0_out;
		logic [7:0]  p0_oe;
		logic [7:0]  p1_out;
		logic [3:0]  p4_out;
		logic        rd_n;
		logic        wr_n;
		logic        ale;
		logic        p2_en;
		logic        cbank;
		logic        lsel;
	} edb_regs_t;

	edb_regs_t   r;
	edb_regs_t   next_r;
	logic [3:0]  cs_hit;
	logic [15:0] cs_ctrl;
	logic [7:0]  ram_rdata;
	logic        ram_we;
	logic        ram_hit;
	logic        mc_tick;
	logic        key_open;
	logic [7:0]  rd_val;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cs
			edb_cs_match u_match (
				.addr  (r.addr),
				.base  (r.bases[16*g +: 16]),
				.width (cs_ctrl[4*g +: 2]),
				.hit   (cs_hit[g])
			);
		end
	endgenerate

	edb_xram u_ram (
		.clk   (clk),
		.we    (ram_we),
		// The move address only stands with the request, so later cycles use the held copy.
		.addr  ((r.st == EDB_IDLE) ? mx_addr[9:0] : r.addr[9:0]),
		.wdata (mx_wdata),
		.rdata (ram_rdata)
	);

	// Internal RAM only answers when enabled and within the low 1 KB.
	assign ram_hit  = r.xctl[EDB_XRAM_EN_BIT] && (mx_addr <= EDB_XRAM_TOP);
	assign ram_we   = (r.st == EDB_IDLE) && mx_req && mx_write && ram_hit;
	assign mc_tick  = (r.mc_div == 2'(EDB_CLK_PER_MC - 1));
	assign cs_ctrl  = {r.ctrl_b, r.ctrl_a};
	assign key_open = (r.key_cnt != 5'h00);

	always_comb begin
		logic [1:0] mode;
		mode   = 2'h0;
		next_r = r;
		next_r.done = 1'b0;
		next_r.mc_div = 2'(r.mc_div + 2'h1);
		if (key_open) begin
			next_r.key_cnt = 5'(r.key_cnt - 5'h01);
		end
		// Register writes.
		if (sfr_wr) begin
			next_r.key_half = 1'b0;
			if (sfr_addr == EDB_ADR_TKEY) begin
				next_r.key_half = (sfr_wdata == EDB_KEY_FIRST);
				if (r.key_half && sfr_wdata == EDB_KEY_SECOND) begin
					next_r.key_cnt = 5'(EDB_KEY_WINDOW_MC * EDB_CLK_PER_MC);
				end
			end else if (sfr_addr == EDB_ADR_PORT0) begin
				next_r.p0_lat = sfr_wdata;
			end else if (sfr_addr == EDB_ADR_P1) begin
				next_r.p1_lat = sfr_wdata;
			end else if (sfr_addr == EDB_ADR_P4) begin
				next_r.p4_lat = sfr_wdata[3:0];
			end else if (sfr_addr == EDB_ADR_CLK_STRETCH) begin
				next_r.stretch = sfr_wdata;
			end else if (sfr_addr == EDB_ADR_CS_CTRL_A) begin
				next_r.ctrl_a = sfr_wdata;
			end else if (sfr_addr == EDB_ADR_CS_CTRL_B) begin
				next_r.ctrl_b = sfr_wdata;
			end else if (sfr_addr >= EDB_ADR_CS0_LOW && sfr_addr <= EDB_ADR_CS1_HIGH) begin
				next_r.bases[8*(sfr_addr - EDB_ADR_CS0_LOW) +: 8] = sfr_wdata;
			end else if (sfr_addr >= EDB_ADR_CS2_LOW && sfr_addr <= EDB_ADR_CS3_HIGH) begin
				next_r.bases[32 + 8*(sfr_addr - EDB_ADR_CS2_LOW) +: 8] = sfr_wdata;
			end else if (sfr_addr == EDB_ADR_MISC) begin
				next_r.misc = sfr_wdata;
			end else if (sfr_addr == EDB_ADR_XRAM_CTRL) begin
				next_r.xctl = sfr_wdata;
			end else if (sfr_addr == EDB_ADR_BANK && key_open) begin
				// Banking changes the code map under the running program, so it is key guarded.
				next_r.bank = {4'h0, sfr_wdata[3:0]};
			end
		end
		// Register reads: ports give pins except during read-modify-write.
		rd_val = 8'h00;
		if (sfr_addr == EDB_ADR_PORT0) begin
			rd_val = sfr_rmw ? r.p0_lat : p0_in;
		end else if (sfr_addr == EDB_ADR_P1) begin
			rd_val = sfr_rmw ? r.p1_lat : p1_in;
		end else if (sfr_addr == EDB_ADR_P4) begin
			rd_val = {4'h0, sfr_rmw ? r.p4_lat : p4_in};
		end else if (sfr_addr == EDB_ADR_CLK_STRETCH) begin
			rd_val = r.stretch;
		end else if (sfr_addr == EDB_ADR_CS_CTRL_A) begin
			rd_val = r.ctrl_a;
		end else if (sfr_addr == EDB_ADR_CS_CTRL_B) begin
			rd_val = r.ctrl_b;
		end else if (sfr_addr == EDB_ADR_MISC) begin
			rd_val = r.misc;
		end else if (sfr_addr == EDB_ADR_XRAM_CTRL) begin
			rd_val = r.xctl;
		end else if (sfr_addr == EDB_ADR_BANK) begin
			rd_val = r.bank;
		end else if (sfr_addr >= EDB_ADR_CS0_LOW && sfr_addr <= EDB_ADR_CS1_HIGH) begin
			rd_val = r.bases[8*(sfr_addr - EDB_ADR_CS0_LOW) +: 8];
		end else if (sfr_addr >= EDB_ADR_CS2_LOW && sfr_addr <= EDB_ADR_CS3_HIGH) begin
			rd_val = r.bases[32 + 8*(sfr_addr - EDB_ADR_CS2_LOW) +: 8];
		end
		if (sfr_rd) begin
			next_r.rdata = rd_val;
		end
		// Move sequencer, counted in machine cycles of four clocks.
		case (r.st)
			EDB_IDLE: begin
				if (mx_req) begin
					next_r.addr   = mx_addr;
					next_r.wr     = mx_write;
					next_r.wdat   = mx_wdata;
					next_r.mc_div = 2'h0;
					if (ram_hit) begin
						next_r.st      = EDB_IRAM;
						next_r.mc_left = 4'(EDB_BASE_MC * EDB_CLK_PER_MC / 4 - 1);
					end else begin
						next_r.st      = EDB_ADDR;
						next_r.ale     = 1'b1;
						next_r.p2_en   = 1'b1;
						next_r.p0_out  = mx_addr[7:0];
						next_r.p0_oe   = 8'hff;
						next_r.mc_left = 4'(EDB_BASE_MC + {1'b0, r.stretch[2:0]} - 4'h1);
					end
				end
			end
			EDB_ADDR: begin
				if (mc_tick) begin
					next_r.st    = EDB_STRB;
					next_r.ale   = 1'b0;
					next_r.rd_n  = r.wr;
					next_r.wr_n  = ~r.wr;
					next_r.p0_out = r.wdat;
					next_r.p0_oe  = {8{r.wr}};
					for (int i = 0; i < 4; i++) begin
						mode = cs_ctrl[4*i + 2 +: 2];
						if (cs_hit[i] && mode[r.wr ? 1 : 0]) begin
							next_r.p4_out[i] = 1'b0;
						end
					end
				end
			end
			EDB_STRB: begin
				if (mc_tick) begin
					next_r.mc_left = 4'(r.mc_left - 4'h1);
					if (r.mc_left == 4'h1) begin
						next_r.mrdata = p0_in;
						next_r.st     = EDB_DONE;
						next_r.rd_n   = 1'b1;
						next_r.wr_n   = 1'b1;
						next_r.p0_oe  = 8'h00;
						next_r.p2_en  = 1'b0;
						next_r.p4_out = r.p4_lat;
					end
				end
			end
			EDB_IRAM: begin
				if (mc_tick) begin
					next_r.mc_left = 4'(r.mc_left - 4'h1);
					if (r.mc_left == 4'h0) begin
						next_r.mrdata = ram_rdata;
						next_r.st     = EDB_DONE;
					end
				end
			end
			EDB_DONE: begin
				next_r.done = 1'b1;
				next_r.st   = EDB_IDLE;
			end
			default: begin
				next_r.st = EDB_IDLE;
			end
		endcase
		// A request taken in idle must keep the address that the sequencer put on port 0.
		if ((r.st == EDB_IDLE && !mx_req) || r.st == EDB_DONE) begin
			next_r.p4_out = r.p4_lat;
			next_r.p0_out = r.p0_lat;
			// Latch drives low only: open-drain port.
			next_r.p0_oe  = ~r.p0_lat;
		end
		// While banking is on, code_bank takes the selected port-1 latch bit; that pin keeps its latch value.
		next_r.p1_out = r.p1_lat;
		next_r.cbank  = 1'b0;
		if (r.bank[EDB_BANK_EN_BIT]) begin
			next_r.cbank = r.p1_lat[r.bank[2:0]];
			next_r.p1_out[r.bank[2:0]] = r.p1_lat[r.bank[2:0]];
		end
		next_r.lsel = code_fetch && code_loader;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			r         <= '0;
			r.st      <= EDB_IDLE;
			r.stretch <= EDB_RST_STRETCH;
			r.bank    <= EDB_RST_BANK;
			r.p0_lat  <= EDB_RST_PORT;
			r.p1_lat  <= EDB_RST_PORT;
			r.p4_lat  <= 4'hf;
			r.p0_out  <= EDB_RST_PORT;
			r.p1_out  <= EDB_RST_PORT;
			r.p4_out  <= 4'hf;
			r.rd_n    <= 1'b1;
			r.wr_n    <= 1'b1;
			r.xctl    <= EDB_RST_ZERO;
		end else begin
			r <= next_r;
		end
	end

	assign sfr_rdata  = r.rdata;
	assign mx_done    = r.done;
	assign mx_rdata   = r.mrdata;
	assign code_bank  = r.cbank;
	assign loader_sel = r.lsel;
	assign p0_out     = r.p0_out;
	assign p0_oe      = r.p0_oe;
	assign p0_pullup  = r.misc[EDB_PULLUP_BIT];
	assign p2_out     = r.addr[15:8];
	assign p2_addr_en = r.p2_en;
	assign p1_out     = r.p1_out;
	assign p4_out     = r.p4_out;
	assign rd_n       = r.rd_n;
	assign wr_n       = r.wr_n;
	assign ale        = r.ale;

	a_strobe_excl: assert property (@(posedge clk) disable iff (!rst_n)
		!(!rd_n && !wr_n)) else $error("read and write strobes both low");
	a_cs_in_strobe: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st != EDB_STRB && r.st != EDB_DONE && $past(r.st) != EDB_STRB) |->
		p4_out == r.p4_lat || $past(r.p4_lat) != r.p4_lat) else $error("chip select outside strobe");
	a_iram_two_mc: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == EDB_IDLE && mx_req && ram_hit) |-> ##10 mx_done) else $error("internal move not two cycles");
	a_ext_len: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == EDB_IDLE && mx_req && !ram_hit && r.stretch[2:0] == 3'h0) |-> ##10 mx_done)
		else $error("external move length wrong");
	a_ram_no_strobe: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == EDB_IRAM) |-> (rd_n && wr_n && !ale)) else $error("bus strobed for internal RAM");
	a_p2_addr: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == EDB_STRB) |-> p2_addr_en && p2_out == r.addr[15:8]) else $error("port 2 address lost");
	a_p0_addr_phase: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == EDB_ADDR) |-> p0_out == r.addr[7:0]) else $error("port 0 address missing");
	a_key_window: assert property (@(posedge clk) disable iff (!rst_n)
		(r.key_cnt == 5'd12) |-> ##12 !key_open) else $error("key window not three cycles");
endmodule
`default_nettype wire

// ### hdl/edb_pkg.sv
// Package of register offsets, field positions, reset values and states for the bus decoder.
package edb_pkg;
	localparam logic [7:0] EDB_ADR_PORT0      = 8'h80;
	localparam logic [7:0] EDB_ADR_CLK_STRETCH = 8'h8e;
	localparam logic [7:0] EDB_ADR_P1         = 8'h90;
	localparam logic [7:0] EDB_ADR_CS_CTRL_A  = 8'h92;
	localparam logic [7:0] EDB_ADR_CS_CTRL_B  = 8'h93;
	localparam logic [7:0] EDB_ADR_CS0_LOW    = 8'h94;
	localparam logic [7:0] EDB_ADR_CS0_HIGH   = 8'h95;
	localparam logic [7:0] EDB_ADR_CS1_LOW    = 8'h96;
	localparam logic [7:0] EDB_ADR_CS1_HIGH   = 8'h97;
	localparam logic [7:0] EDB_ADR_CS2_LOW    = 8'h9a;
	localparam logic [7:0] EDB_ADR_CS2_HIGH   = 8'h9b;
	localparam logic [7:0] EDB_ADR_CS3_LOW    = 8'h9c;
	localparam logic [7:0] EDB_ADR_CS3_HIGH   = 8'h9d;
	localparam logic [7:0] EDB_ADR_MISC       = 8'ha2;
	localparam logic [7:0] EDB_ADR_P4         = 8'ha5;
	localparam logic [7:0] EDB_ADR_BANK       = 8'hab;
	localparam logic [7:0] EDB_ADR_TKEY       = 8'hc7;
	localparam logic [7:0] EDB_ADR_XRAM_CTRL  = 8'hc6;
	localparam logic [7:0] EDB_KEY_FIRST      = 8'haa;
	localparam logic [7:0] EDB_KEY_SECOND     = 8'h55;
	localparam logic [7:0] EDB_RST_STRETCH    = 8'h01;
	localparam logic [7:0] EDB_RST_BANK       = 8'h07;
	localparam logic [7:0] EDB_RST_PORT       = 8'hff;
	localparam logic [7:0] EDB_RST_ZERO       = 8'h00;
	localparam int         EDB_STRETCH_LSB    = 0;
	localparam int         EDB_BANK_EN_BIT    = 3;
	localparam int         EDB_PULLUP_BIT     = 0;
	localparam int         EDB_XRAM_EN_BIT    = 0;
	localparam logic [15:0] EDB_XRAM_TOP      = 16'h03ff;
	localparam int         EDB_CLK_PER_MC     = 4;
	localparam logic [3:0] EDB_BASE_MC        = 4'h2;
	localparam logic [2:0] EDB_KEY_WINDOW_MC  = 3'h3;
	localparam logic [1:0] EDB_MODE_READ      = 2'h1;
	localparam logic [1:0] EDB_MODE_WRITE     = 2'h2;
	localparam logic [1:0] EDB_CMP_FULL       = 2'h0;
	localparam logic [1:0] EDB_CMP_A15_A1     = 2'h1;
	localparam logic [1:0] EDB_CMP_A15_A2     = 2'h2;
	typedef enum logic [4:0] {
		EDB_IDLE  = 5'b00001,
		EDB_ADDR  = 5'b00010,
		EDB_STRB  = 5'b00100,
		EDB_IRAM  = 5'b01000,
		EDB_DONE  = 5'b10000
	} edb_state_t;
endpackage

// ### hdl/edb_xram.sv
// On-chip 1 KB data RAM reachable only by external-move accesses.
`timescale 1ns/10ps
`default_nettype none
module edb_xram
	import edb_pkg::*;
(
	input  wire logic       clk,   // System clock.
	input  wire logic       we,    // Write enable.
	input  wire logic [9:0] addr,  // Word address.
	input  wire logic [7:0] wdata, // Write data.
	output logic      [7:0] rdata  // Registered read data.
);
	logic [7:0] mem [0:1023];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule
`default_nettype wire

// ### hdl/edb_cs_match.sv
// Address match for one chip-select pin with selectable compare width.
`timescale 1ns/10ps
`default_nettype none
module edb_cs_match
	import edb_pkg::*;
(
	input  wire logic [15:0] addr,  // Bus address of the move.
	input  wire logic [15:0] base,  // Programmed base address.
	input  wire logic [1:0]  width, // Compare width code.
	output logic             hit    // Masked address equals masked base.
);
	logic [15:0] mask;

	always_comb begin
		if (width == EDB_CMP_FULL) begin
			mask = 16'hffff;
		end else if (width == EDB_CMP_A15_A1) begin
			mask = 16'hfffe;
		end else if (width == EDB_CMP_A15_A2) begin
			mask = 16'hfffc;
		end else begin
			mask = 16'hff00;
		end
		hit = ((addr ^ base) & mask) == 16'h0000;
	end
endmodule
`default_nettype wire

// ### verification/edb_ext_mem.sv
// External memory on the multiplexed port 0 and 2 bus, with a settable read access time.
`timescale 1ns/10ps
`default_nettype none
module edb_ext_mem (
	input  wire logic       clk,       // System clock.
	input  wire logic       ale,       // Address latch enable.
	input  wire logic [7:0] p0_out,    // Port 0 drive value.
	input  wire logic [7:0] p0_oe,     // Port 0 drive enables.
	input  wire logic       p0_pullup, // Port 0 pull-ups on.
	input  wire logic [7:0] p2_out,    // High address byte.
	input  wire logic       rd_n,      // Read strobe, active low.
	input  wire logic       wr_n,      // Write strobe, active low.
	input  wire logic [3:0] lag,       // Read strobe clocks before data is valid.
	output logic      [7:0] p0_in      // Resolved port 0 level.
);
	logic [7:0]  mem [0:65535];
	logic [15:0] addr;
	logic [7:0]  last = 8'h00;
	logic [3:0]  rd_cnt;
	logic [7:0]  src;
	// A slow part shows a changing pattern, or all ones with the pull-ups on, until its access time runs out, as a real bus would.
	always_comb begin
		if (rd_n === 1'b0 && rd_cnt >= lag) begin
			src = mem[addr];
		end else if (p0_pullup === 1'b1) begin
			src = 8'hff;
		end else begin
			src = ~last;
		end
		p0_in = (p0_oe & p0_out) | (~p0_oe & src);
	end
	always_ff @(posedge clk) begin
		last <= p0_in;
		rd_cnt <= rd_n ? 4'h0 : ((rd_cnt == 4'hf) ? rd_cnt : rd_cnt + 4'h1);
		if (ale === 1'b1) begin
			addr <= {p2_out, p0_out};
		end
		if (wr_n === 1'b0) begin
			mem[addr] <= p0_out;
		end
	end
endmodule
`default_nettype wire

// ### verification/test_ext_data_bus_chip_select.sv
// Self-checking bench for the bus decoder against an external memory model.
`timescale 1ns/10ps
`default_nettype none
module test_ext_data_bus_chip_select
	import edb_pkg::*;
;
	logic        clk, rst_n, sfr_wr, sfr_rd, sfr_rmw, mx_req, mx_write, code_loader, code_fetch;
	logic        mx_done, code_bank, loader_sel, p0_pullup, p2_addr_en, rd_n, wr_n, ale, rd_seen;
	logic [3:0]  p4_in, p4_out, lag;
	logic [7:0]  sfr_addr, sfr_wdata, mx_wdata, p1_in, sfr_rdata, mx_rdata, v;
	logic [7:0]  p0_in, p0_out, p0_oe, p2_out, p1_out;
	logic [8:0]  note;
	logic [15:0] mx_addr, a;
	logic [31:0] seed;
	logic [1:0]  mode, cmp;
	int          n_mismatch, n_checks, i;
	logic [7:0]  q_sfr[$];
	logic [8:0]  q_mx[$];

	edb_bus_ctrl dut (.clk(clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_rmw(sfr_rmw), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.mx_req(mx_req), .mx_write(mx_write), .mx_addr(mx_addr), .mx_wdata(mx_wdata),
		.mx_done(mx_done), .mx_rdata(mx_rdata), .code_loader(code_loader),
		.code_fetch(code_fetch), .code_bank(code_bank), .loader_sel(loader_sel), .p0_in(p0_in),
		.p0_out(p0_out), .p0_oe(p0_oe), .p0_pullup(p0_pullup), .p2_out(p2_out),
		.p2_addr_en(p2_addr_en), .p1_in(p1_in), .p1_out(p1_out), .p4_in(p4_in),
		.p4_out(p4_out), .rd_n(rd_n), .wr_n(wr_n), .ale(ale));
	edb_ext_mem mem (.clk(clk), .ale(ale), .p0_out(p0_out), .p0_oe(p0_oe),
		.p0_pullup(p0_pullup), .p2_out(p2_out), .rd_n(rd_n), .wr_n(wr_n), .lag(lag),
		.p0_in(p0_in));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] r;
		r = x ^ (x << 13);
		r = r ^ (r >> 17);
		return r ^ (r << 5);
	endfunction
	function automatic logic [15:0] cmask(input logic [1:0] c);
		case (c)
			2'h0: return 16'hffff;
			2'h1: return 16'hfffe;
			2'h2: return 16'hfffc;
			default: return 16'hff00;
		endcase
	endfunction
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		check("pending notes", 8'h00, 8'(q_sfr.size() + q_mx.size()));
		$display("TB: %0d checks, %0d mismatches", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Writes and reads leave their strobe up so that key writes land on consecutive edges.
	task automatic idle(input int n);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		sfr_wr <= 1'b1;
		sfr_rd <= 1'b0;
		sfr_addr <= ad;
		sfr_wdata <= d;
		@(posedge clk);
	endtask
	task automatic wr1(input logic [7:0] ad, input logic [7:0] d);
		wr(ad, d);
		idle(1);
	endtask
	task automatic rd(input logic [7:0] ad, input logic rmw, input logic [7:0] exp);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b1;
		sfr_rmw <= rmw;
		sfr_addr <= ad;
		q_sfr.push_back(exp);
		@(posedge clk);
	endtask
	task automatic mv(input logic w, input logic [15:0] ad, input logic [7:0] d,
		input logic ext, input int s, input logic [1:0] ecs);
		int         n;
		logic       strb, bad;
		logic [1:0] cs;
		strb = 1'b0;
		bad = 1'b0;
		cs = 2'b00;
		mx_req <= 1'b1;
		mx_write <= w;
		mx_addr <= ad;
		mx_wdata <= d;
		q_mx.push_back({~w, d});
		@(posedge clk);
		mx_req <= 1'b0;
		for (n = 1; n < 60; n++) begin
			@(posedge clk);
			@(negedge clk);
			if (ale === 1'b1 && {p2_out, p0_out, p0_oe} !== {ad, 8'hff}) bad = 1'b1;
			if (wr_n === 1'b0 && p0_out !== d) bad = 1'b1;
			if (rd_n === 1'b0 || wr_n === 1'b0) begin
				strb = 1'b1;
				cs = cs | ~p4_out[1:0];
			end else if (p4_out[1:0] !== 2'b11) begin
				bad = 1'b1;
			end
			if (mx_done === 1'b1) break;
		end
		check("move cycles", 8'(ext ? 9 + 4 * s : 9), 8'(n));
		check("move route", {7'h0, ext}, {7'h0, strb});
		check("chip selects", {6'h0, ecs}, {6'h0, cs});
		check("bus phases", 8'h00, {7'h0, bad});
		if (n == 60) print_verdict();
		@(posedge clk);
	endtask

	always @(posedge clk) rd_seen <= sfr_rd;
	always @(negedge clk) begin
		if (rd_seen === 1'b1 && q_sfr.size() > 0) check("register", q_sfr.pop_front(), sfr_rdata);
		if (mx_done === 1'b1 && q_mx.size() > 0) begin
			note = q_mx.pop_front();
			if (note[8] === 1'b1) check("move data", note[7:0], mx_rdata);
		end
	end

	initial begin
		{rst_n, sfr_wr, sfr_rd, sfr_rmw, mx_req, mx_write, code_loader, code_fetch} = 8'h00;
		{sfr_addr, sfr_wdata, mx_wdata, mx_addr, lag} = 36'h0_0000_0000;
		n_mismatch = 0;
		n_checks = 0;
		seed = xs(32'h6c96);
		p1_in = seed[7:0];
		p4_in = seed[11:8];
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		check("idle outputs", 8'hfc, {p4_out, rd_n, wr_n, code_bank, p0_pullup});
		@(posedge clk);
		rd(EDB_ADR_CLK_STRETCH, 1'b0, EDB_RST_STRETCH);
		rd(EDB_ADR_BANK, 1'b0, EDB_RST_BANK);
		rd(EDB_ADR_PORT0, 1'b1, EDB_RST_PORT);
		rd(8'h81, 1'b0, EDB_RST_ZERO);
		wr1(EDB_ADR_P1, ~p1_in);
		rd(EDB_ADR_P1, 1'b1, ~p1_in);
		rd(EDB_ADR_P1, 1'b0, p1_in);
		idle(1);
		@(negedge clk);
		check("port 1 out", ~p1_in, p1_out);
		@(posedge clk);
		for (i = 0; i < 4; i++) begin
			seed = xs(seed);
			wr1(EDB_ADR_CS0_LOW + 8'(i), seed[7:0]);
			rd(EDB_ADR_CS0_LOW + 8'(i), 1'b0, seed[7:0]);
			idle(1);
		end
		wr1(EDB_ADR_MISC, 8'h01);
		@(negedge clk);
		check("pull-up", 8'h01, {7'h0, p0_pullup});
		@(posedge clk);
		wr1(EDB_ADR_MISC, 8'h00);
		wr1(EDB_ADR_CS_CTRL_A, 8'h00);
		mv(1'b1, 16'h0010, 8'ha5, 1'b1, 1, 2'b00);
		mv(1'b0, 16'h0010, 8'ha5, 1'b1, 1, 2'b00);
		for (i = 0; i < 8; i++) begin
			mode = 2'(i + 1);
			cmp = 2'(i >> 1);
			seed = xs(seed);
			v = seed[7:0];
			a = (i == 4) ? 16'h1234 : 16'h1234 ^ {13'h0, seed[10:8]};
			wr(EDB_ADR_CLK_STRETCH, 8'(i));
			wr(EDB_ADR_CS_CTRL_A, {4'b1000, mode, cmp});
			wr(EDB_ADR_CS0_LOW, 8'h34);
			wr(EDB_ADR_CS0_HIGH, 8'h12);
			wr(EDB_ADR_CS1_LOW, 8'h34);
			wr(EDB_ADR_CS1_HIGH, 8'h12);
			rd(EDB_ADR_CS_CTRL_A, 1'b0, {4'b1000, mode, cmp});
			idle(1);
			lag <= 4'(2 * i + 1);
			mv(1'b1, a, v, 1'b1, i, {a == 16'h1234, ((a ^ 16'h1234) & cmask(cmp)) == 16'h0000
				&& mode[1]});
			mv(1'b0, a, v, 1'b1, i, {1'b0, ((a ^ 16'h1234) & cmask(cmp)) == 16'h0000
				&& mode[0]});
		end
		wr1(EDB_ADR_XRAM_CTRL, 8'h01);
		mv(1'b1, 16'h03ff, v, 1'b0, 7, 2'b00);
		mv(1'b0, 16'h03ff, v, 1'b0, 7, 2'b00);
		mv(1'b1, 16'h0010, ~v, 1'b0, 7, 2'b00);
		mv(1'b1, 16'h0400, v, 1'b1, 7, 2'b00);
		mv(1'b0, 16'h0400, v, 1'b1, 7, 2'b00);
		wr1(EDB_ADR_XRAM_CTRL, 8'h00);
		mv(1'b0, 16'h0010, 8'ha5, 1'b1, 7, 2'b00);
		wr1(EDB_ADR_BANK, 8'h08);
		rd(EDB_ADR_BANK, 1'b0, EDB_RST_BANK);
		idle(1);
		for (i = 0; i < 8; i++) begin
			seed = xs(seed);
			v = seed[7:0];
			wr(EDB_ADR_TKEY, EDB_KEY_FIRST);
			wr(EDB_ADR_TKEY, EDB_KEY_SECOND);
			wr(EDB_ADR_BANK, 8'h08 | 8'(i));
			wr(EDB_ADR_P1, v);
			idle(8);
			@(negedge clk);
			check("high address line", {7'h0, v[i]}, {7'h0, code_bank});
			@(posedge clk);
		end
		wr(EDB_ADR_TKEY, EDB_KEY_FIRST);
		wr(EDB_ADR_TKEY, EDB_KEY_SECOND);
		idle(13);
		wr1(EDB_ADR_BANK, 8'h07);
		rd(EDB_ADR_BANK, 1'b0, 8'h0f);
		wr(EDB_ADR_P1, 8'hff);
		wr(EDB_ADR_TKEY, EDB_KEY_FIRST);
		wr(EDB_ADR_TKEY, EDB_KEY_SECOND);
		wr1(EDB_ADR_BANK, 8'h07);
		code_fetch <= 1'b1;
		code_loader <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("bank off", 8'h00, {7'h0, code_bank});
		check("loader select", 8'h01, {7'h0, loader_sel});
		@(posedge clk);
		code_loader <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("loader select", 8'h00, {7'h0, loader_sel});
		print_verdict();
	end
endmodule
`default_nettype wire
